// ==== verilog/rf_front_config_regs.sv ====
// Configuration register bank of a contactless frontend.
// Assumes an Avalon-MM master on core_clk with word addressing.
//
// Summary of operation
// [RQ1] Receiver config register at 26h, reset 48h, all bits read/write.
// [RQ2] Bit 7 of receiver config enables the level-detector amplifier.
// [RQ3] Bits 6:4 select receiver gain from 18 to 48 dB.
// [RQ4] Bits 3:0 pass unchanged as level-detector sensitivity.
// [RQ5] Driver-on N register at 27h, reset 88h, all bits read/write.
// [RQ6] Its upper nibble is unmodulated N conductance with drivers on.
// [RQ7] Its lower nibble is modulated N conductance with drivers on.
// [RQ8] Unmodulated N value comes from on register if a driver is on.
// [RQ9] Modulated N value comes from on register if a driver is on.
// [RQ10] Soft power-down forces each delivered conductance top bit high.
// [RQ11] P-driver unmodulated register at 28h, reset 20h.
// [RQ12] Its bits 7:6 are reserved and read as zero.
// [RQ13] Its bits 5:0 are read/write P-driver unmodulated conductance.
// [RQ14] Driver-off N register at 23h, reset 88h, same nibble layout.
// [RQ15] Reads return stored values without side effects; writes act next edge.
// [RQ16] Writes to reserved P-register bits are dropped.
`timescale 1ns/1ps
`include "rf_front_map.svh"

module rf_front_config_regs
   import rf_front_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   output logic level_detector_amp_enable,
   output logic [2:0] receiver_gain_select,
   output logic [3:0] level_detector_sensitivity,
   output nib_t n_drive_unmodulated,
   output nib_t n_drive_modulated,
   output logic [5:0] p_drive_unmodulated,
   output logic antenna_drive_a,
   output logic antenna_drive_b,
   output logic soft_power_down
);

   // ====================================================================
   // Register storage
   reg8_t rx_cfg_ff;
   reg8_t n_on_ff;
   reg8_t n_off_ff;
   reg8_t p_cw_ff;
   reg8_t ctrl_ff;
   bus_state_e bus_state_ff;
   bus_state_e nxt_bus_state;
   logic [31:0] rdata_ff;
   logic [1:0] resp_ff;
   logic wait_ff;

   // ====================================================================
   // Decode helpers
   function automatic logic is_mapped(input logic [5:0] a);
      is_mapped = (a == `IDX_RX_CFG) || (a == `IDX_N_DRV_ON) || (a == `IDX_N_DRV_OFF) ||
         (a == `IDX_P_DRV_CW) || (a == `IDX_CTRL);
   endfunction

   function automatic reg8_t read_mux(input logic [5:0] a, input reg8_t rx, input reg8_t non,
      input reg8_t noff, input reg8_t pcw, input reg8_t ctl);
      case (a)
         `IDX_RX_CFG: read_mux = rx;
         `IDX_N_DRV_ON: read_mux = non;
         `IDX_N_DRV_OFF: read_mux = noff;
         `IDX_P_DRV_CW: read_mux = pcw & `P_DRV_MASK; // [RQ12]
         `IDX_CTRL: read_mux = ctl;
         default: read_mux = 8'h00;
      endcase
   endfunction

   logic req;
   logic wr_go;
   assign req = (avs_read | avs_write) & (bus_state_ff == bus_idle);
   assign wr_go = req & avs_write & avs_byteenable[0];

   // ====================================================================
   // Bus slave state
   always_comb begin
      case (bus_state_ff)
         bus_idle: nxt_bus_state = req ? bus_ack : bus_idle;
         bus_ack: nxt_bus_state = bus_idle;
         default: nxt_bus_state = bus_idle;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         bus_state_ff <= bus_idle;
      end else if (clk_en) begin
         bus_state_ff <= nxt_bus_state;
      end
   end

   // Waitrequest high except the single answer cycle
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wait_ff <= 1'b1;
      end else if (clk_en) begin
         wait_ff <= ~req;
      end
   end

   // Read data and response, no side effects on read
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata_ff <= 32'h0000_0000;
         resp_ff <= 2'b00;
      end else if (clk_en) begin
         if (req) begin
            rdata_ff <= avs_read ? {24'h00_0000, read_mux(avs_address, rx_cfg_ff, n_on_ff,
               n_off_ff, p_cw_ff, ctrl_ff)} : 32'h0000_0000; // [RQ15]
            resp_ff <= is_mapped(avs_address) ? 2'b00 : 2'b11;
         end
      end
   end

   // ====================================================================
   // Register writes
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rx_cfg_ff <= `RST_RX_CFG; // [RQ1]
      end else if (clk_en && wr_go && avs_address == `IDX_RX_CFG) begin
         rx_cfg_ff <= avs_writedata[7:0]; // [RQ1] [RQ15]
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         n_on_ff <= `RST_N_DRV_ON; // [RQ5]
      end else if (clk_en && wr_go && avs_address == `IDX_N_DRV_ON) begin
         n_on_ff <= avs_writedata[7:0]; // [RQ5]
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         n_off_ff <= `RST_N_DRV_OFF; // [RQ14]
      end else if (clk_en && wr_go && avs_address == `IDX_N_DRV_OFF) begin
         n_off_ff <= avs_writedata[7:0]; // [RQ14]
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         p_cw_ff <= `RST_P_DRV_CW; // [RQ11]
      end else if (clk_en && wr_go && avs_address == `IDX_P_DRV_CW) begin
         p_cw_ff <= avs_writedata[7:0] & `P_DRV_MASK; // [RQ13] [RQ16]
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_ff <= `RST_CTRL;
      end else if (clk_en && wr_go && avs_address == `IDX_CTRL) begin
         ctrl_ff <= avs_writedata[7:0] & `CTRL_MASK;
      end
   end

   // ====================================================================
   // Receiver outputs
   always_ff @(posedge core_clk) begin
      if (srst) begin
         level_detector_amp_enable <= 1'b0;
         receiver_gain_select <= 3'b100;
         level_detector_sensitivity <= 4'h8;
      end else if (clk_en) begin
         level_detector_amp_enable <= rx_cfg_ff[`RX_AMP_BIT]; // [RQ2]
         receiver_gain_select <= rx_cfg_ff[`RX_GAIN_HI:`RX_GAIN_LO]; // [RQ3]
         level_detector_sensitivity <= rx_cfg_ff[`RX_LVL_HI:`RX_LVL_LO]; // [RQ4]
      end
   end

   // Control outputs
   always_ff @(posedge core_clk) begin
      if (srst) begin
         antenna_drive_a <= 1'b0;
         antenna_drive_b <= 1'b0;
         soft_power_down <= 1'b0;
      end else if (clk_en) begin
         antenna_drive_a <= ctrl_ff[`CTRL_DRV_A_BIT];
         antenna_drive_b <= ctrl_ff[`CTRL_DRV_B_BIT];
         soft_power_down <= ctrl_ff[`CTRL_PDOWN_BIT];
      end
   end

   // ====================================================================
   // Driver conductance selection
   rf_front_drive_sel u_drive_sel (
      .core_clk(core_clk),
      .srst(srst),
      .clk_en(clk_en),
      .n_on_reg(n_on_ff), // [RQ6] [RQ7]
      .n_off_reg(n_off_ff),
      .p_cw_reg(p_cw_ff),
      .drivers_on(ctrl_ff[`CTRL_DRV_A_BIT] | ctrl_ff[`CTRL_DRV_B_BIT]), // [RQ8] [RQ9]
      .soft_pdown(ctrl_ff[`CTRL_PDOWN_BIT]), // [RQ10]
      .n_cw_ff(n_drive_unmodulated),
      .n_mod_ff(n_drive_modulated),
      .p_cw_ff(p_drive_unmodulated)
   );

   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign avs_response = resp_ff;

endmodule

// ==== verilog/rf_front_map.svh ====
// Register map constants for the frontend configuration bank.
// Assumes word-addressed Avalon-MM; byte address is four times the index.
`ifndef RF_FRONT_MAP_SVH
`define RF_FRONT_MAP_SVH

// ====================================================================
// Register indices and reset values
`define IDX_N_DRV_OFF 6'h23
`define IDX_RX_CFG 6'h26
`define IDX_N_DRV_ON 6'h27
`define IDX_P_DRV_CW 6'h28
`define IDX_CTRL 6'h30
`define RST_N_DRV_OFF 8'h88
`define RST_RX_CFG 8'h48
`define RST_N_DRV_ON 8'h88
`define RST_P_DRV_CW 8'h20
`define RST_CTRL 8'h00

// ====================================================================
// Field positions
`define RX_AMP_BIT 7
`define RX_GAIN_HI 6
`define RX_GAIN_LO 4
`define RX_LVL_HI 3
`define RX_LVL_LO 0
`define P_DRV_MASK 8'h3f
`define CTRL_DRV_A_BIT 0
`define CTRL_DRV_B_BIT 1
`define CTRL_PDOWN_BIT 2
`define CTRL_MASK 8'h07

`endif

// ==== verilog/rf_front_pkg.sv ====
// Types shared by the frontend configuration bank.
// Assumes the map header supplies all numeric constants.
package rf_front_pkg;

   // ====================================================================
   // Bus slave states
   typedef enum logic [1:0] {
      bus_idle = 2'b00,
      bus_ack = 2'b01
   } bus_state_e;

   typedef logic [7:0] reg8_t;
   typedef logic [3:0] nib_t;

endpackage

// ==== verilog/rf_front_drive_sel.sv ====
// Conductance selection for the antenna N and P drivers.
// Assumes stored register values and driver state arrive on the same clock.
`timescale 1ns/1ps
`include "rf_front_map.svh"

module rf_front_drive_sel
   import rf_front_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire reg8_t n_on_reg,
   input wire reg8_t n_off_reg,
   input wire reg8_t p_cw_reg,
   input wire logic drivers_on,
   input wire logic soft_pdown,
   output nib_t n_cw_ff,
   output nib_t n_mod_ff,
   output logic [5:0] p_cw_ff
);

   // ====================================================================
   // Forcing of the top bit during soft power-down
   function automatic nib_t force_nib(input nib_t v, input logic pd);
      force_nib = {v[3] | pd, v[2:0]};
   endfunction

   nib_t nxt_n_cw;
   nib_t nxt_n_mod;
   logic [5:0] nxt_p_cw;

   always_comb begin
      nxt_n_cw = force_nib(drivers_on ? n_on_reg[7:4] : n_off_reg[7:4], soft_pdown); // [RQ8] [RQ10]
      nxt_n_mod = force_nib(drivers_on ? n_on_reg[3:0] : n_off_reg[3:0], soft_pdown); // [RQ9] [RQ10]
      nxt_p_cw = {p_cw_reg[5] | soft_pdown, p_cw_reg[4:0]}; // [RQ10]
   end

   // ====================================================================
   // Registered driver settings
   always_ff @(posedge core_clk) begin
      if (srst) begin
         n_cw_ff <= 4'h8;
         n_mod_ff <= 4'h8;
         p_cw_ff <= 6'h20;
      end else if (clk_en) begin
         n_cw_ff <= nxt_n_cw;
         n_mod_ff <= nxt_n_mod;
         p_cw_ff <= nxt_p_cw;
      end
   end

endmodule

// ==== tb/rf_front_config_regs_properties.sv ====
// Port checks for the configuration bank.
// Assumes a bind to rf_front_config_regs, one clock domain.
`timescale 1ns/1ps
module rf_front_config_regs_properties
   import rf_front_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] avs_response,
   input wire logic level_detector_amp_enable,
   input wire logic [2:0] receiver_gain_select,
   input wire logic [3:0] level_detector_sensitivity,
   input wire nib_t n_drive_unmodulated,
   input wire nib_t n_drive_modulated,
   input wire logic [5:0] p_drive_unmodulated,
   input wire logic antenna_drive_a,
   input wire logic antenna_drive_b,
   input wire logic soft_power_down
);
   // ===================================
   // Checks
   logic wr26, ans, mapped;
   assign mapped = avs_address inside {6'h23, 6'h26, 6'h27, 6'h28, 6'h30};
   assign ans = !avs_waitrequest && (avs_read || avs_write);
   assign wr26 = avs_write && ans && clk_en && avs_address == 6'h26 && avs_byteenable[0];
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   a_amp_copy: assert property (
      wr26 |=> level_detector_amp_enable == $past(avs_writedata[7]))
      else $error("amp enable not copied");
   a_gain_copy: assert property (
      wr26 |=> receiver_gain_select == $past(avs_writedata[6:4]))
      else $error("gain not copied");
   a_sens_copy: assert property (
      wr26 |=> level_detector_sensitivity == $past(avs_writedata[3:0]))
      else $error("sensitivity not copied");
   a_wait_pulse: assert property (
      !avs_waitrequest && clk_en |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_unmapped_read: assert property (
      ans && avs_read && !mapped |-> avs_response == 2'h3 && avs_readdata == 32'h0)
      else $error("unmapped read answer wrong");
   a_mapped_ok: assert property (
      ans && mapped |-> avs_response == 2'h0)
      else $error("mapped response not ok");
   a_p_reserved: assert property (
      ans && avs_read && avs_address == 6'h28 |-> avs_readdata[31:6] == 26'h0)
      else $error("reserved bits not zero");
   a_pdown_force: assert property (
      soft_power_down |-> n_drive_unmodulated[3] && n_drive_modulated[3] &&
      p_drive_unmodulated[5])
      else $error("power-down top bit not forced");
   a_read_quiet: assert property (
      avs_read && clk_en |=> $stable({level_detector_amp_enable, receiver_gain_select,
      level_detector_sensitivity}))
      else $error("read changed receiver outputs");
   cover property (wr26);
   cover property (!clk_en && avs_write);
   cover property (soft_power_down);
   cover property (ans && avs_read && !mapped);
endmodule

// ==== tb/tb_rf_front_config_regs.sv ====
// Self-checking bench for the configuration bank.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps
module tb_rf_front_config_regs
   import rf_front_pkg::*;
;
   logic core_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [5:0] avs_address = 6'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [3:0] avs_byteenable = 4'h0, level_detector_sensitivity;
   logic [1:0] avs_response, rsp;
   logic avs_waitrequest, level_detector_amp_enable, antenna_drive_a, antenna_drive_b;
   logic soft_power_down;
   logic [2:0] receiver_gain_select;
   nib_t n_drive_unmodulated, n_drive_modulated;
   logic [5:0] p_drive_unmodulated;
   int n_fail = 0, num_checks = 0;
   always #20 core_clk = ~core_clk;
   rf_front_config_regs uut (.*);
   // ===================================
   // Bus and compare
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      avs_read <= !w;
      avs_write <= w;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         n_fail++;
         wrap_up();
      end
      q = avs_readdata;
      rsp = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(negedge core_clk);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] r);
      bus(1'b0, a, 8'h0, 4'hf);
      chk(q, e);
      chk({30'h0, rsp}, {30'h0, r});
   endtask
   // ===================================
   // Scenarios
   task automatic s_reset;
      rd(6'h26, 32'h48, 2'h0);
      rd(6'h27, 32'h88, 2'h0);
      rd(6'h28, 32'h20, 2'h0);
      rd(6'h23, 32'h88, 2'h0);
      chk({level_detector_amp_enable, receiver_gain_select, level_detector_sensitivity},
         32'h48);
      chk({n_drive_unmodulated, n_drive_modulated, p_drive_unmodulated}, 32'h2220);
   endtask
   task automatic s_rx;
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         d = {i[0], i[2:0], 4'hf - i[3:0]};
         bus(1'b1, 6'h26, d, 4'h1);
         chk({level_detector_amp_enable, receiver_gain_select, level_detector_sensitivity},
            d);
         rd(6'h26, d, 2'h0);
      end
   endtask
   task automatic s_p;
      bus(1'b1, 6'h28, 8'hff, 4'h1);
      rd(6'h28, 32'h3f, 2'h0);
      bus(1'b1, 6'h28, 8'h00, 4'h0);
      rd(6'h28, 32'h3f, 2'h0);
   endtask
   task automatic s_sel;
      logic [7:0] c;
      logic [13:0] e;
      logic [7:0] tbl [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07};
      bus(1'b1, 6'h27, 8'ha5, 4'h1);
      bus(1'b1, 6'h23, 8'h3c, 4'h1);
      bus(1'b1, 6'h28, 8'h05, 4'h1);
      foreach (tbl[k]) begin
         c = tbl[k];
         bus(1'b1, 6'h30, c, 4'h1);
         repeat (2) @(negedge core_clk);
         e = (c[0] | c[1]) ? 14'h2945 : 14'h0f05;
         if (c[2]) e = e | 14'h2220;
         chk({n_drive_unmodulated, n_drive_modulated, p_drive_unmodulated}, e);
         chk({soft_power_down, antenna_drive_b, antenna_drive_a}, c);
         rd(6'h27, 32'ha5, 2'h0);
         rd(6'h23, 32'h3c, 2'h0);
      end
   endtask
   task automatic s_refuse;
      bus(1'b1, 6'h3f, 8'hff, 4'h1);
      chk({30'h0, rsp}, 32'h3);
      rd(6'h3f, 32'h0, 2'h3);
      bus(1'b1, 6'h26, 8'h00, 4'h0);
      rd(6'h26, 32'hf8, 2'h0);
   endtask
   task automatic s_freeze;
      @(posedge core_clk);
      clk_en <= 1'b0;
      fork
         bus(1'b1, 6'h26, 8'h15, 4'h1);
         begin
            repeat (4) @(posedge core_clk);
            chk({avs_waitrequest, level_detector_amp_enable, receiver_gain_select,
               level_detector_sensitivity}, 32'h1f8);
            clk_en <= 1'b1;
         end
      join
      chk({level_detector_amp_enable, receiver_gain_select, level_detector_sensitivity},
         32'h15);
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      rd(6'h26, 32'h48, 2'h0);
   endtask
   task automatic wrap_up;
      $display("checks %0d fails %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      s_reset();
      s_rx();
      s_p();
      s_sel();
      s_refuse();
      s_freeze();
      wrap_up();
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      n_fail++;
      wrap_up();
   end
endmodule
bind rf_front_config_regs rf_front_config_regs_properties u_props (.*);
